// [core/ilpc_top.v]
`include "ilpc_consts.vh"

// Notes on behaviour
// - Adjustment amount and direction fields always sent as zero.
// - Control words per frame always advertised as zero.
// - Control bits per sample always sent as zero.
// - High-density flag always sent as zero.
// - Device identifier comes from a software-written register.
// - In 8B/10B formats frames per multiframe come from the multiframe length register.
// - Each lane sends its own lane identifier derived by the block.
// - Octets per frame field follows the selected format.
// - Lane count field follows the selected format.
// - Converter count field is the converter count of the format.
// - Resolution field is sample width before control and tail bits.
// - Bits per sample field is width after control and tail bits.
// - Samples per converter per frame follow the selected format.
// - Checksum is the sum of all fields modulo 256.
// - One format code fixes every derived transport parameter.
// - In 8B/10B formats programmed multiframe length sets framing length in frames.
// - Parameter set is sent only in 8B/10B formats.
// - In 64B/66B formats frames per multiframe are 256 times E over F.

module ilpc_top #(
    parameter LANE_ID_BASE = 5'h00
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // Register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Link layer control
    input  wire       ilas_start,
    input  wire       frame_tick,
    output reg        mf_boundary,
    output wire       ilas_busy,
    output wire       enc_64b66b,
    // Parameter octet stream
    output wire       cfg_valid,
    input  wire       cfg_ready,
    output reg  [2:0] cfg_lane,
    output reg  [3:0] cfg_index,
    output wire [7:0] cfg_octet,
    output reg        cfg_last
);

    // ==========================================
    // States and local constants
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;
    localparam [3:0] LAST_OCTET = `ILPC_OCT_CHK;

    // ==========================================
    // Software registers
    reg  [3:0] format_reg;
    reg  [7:0] klen_reg;
    reg  [7:0] devid_reg;
    reg        scram_reg;

    // Sequencer state
    reg        state_reg;
    reg        state_next;
    reg  [2:0] lane_reg;
    reg  [3:0] idx_reg;
    reg        out_valid_reg;
    reg  [7:0] frame_cnt_reg;

    // Format table outputs
    wire       fmt_valid;
    wire       fmt_enc66;
    wire [3:0] fmt_l;
    wire [3:0] fmt_m;
    wire [3:0] fmt_f;
    wire [3:0] fmt_s;
    wire [3:0] fmt_n;
    wire [3:0] fmt_np;
    wire [1:0] fmt_e;

    // Encoded fields
    wire [4:0] l_m1;
    wire [7:0] f_m1;
    wire [7:0] m_m1;
    wire [4:0] n_m1;
    wire [4:0] np_m1;
    wire [4:0] s_m1;
    wire [9:0] k_66;
    wire [7:0] k_m1;
    wire [4:0] lid;
    wire [2:0] last_lane;
    reg  [11:0] sum_base;
    wire [7:0] chk_base;
    wire [7:0] chk_lane;
    wire       load;
    wire       start_ok;

    // ==========================================
    // Format lookup
    // The whole transport format follows from one code
    ilpc_mode_rom u_rom (
        .clk      (clk),
        .rst_b    (rst_b),
        .mode     (format_reg),
        .valid    (fmt_valid),
        .enc66    (fmt_enc66),
        .lanes    (fmt_l),
        .convs    (fmt_m),
        .octets   (fmt_f),
        .samples  (fmt_s),
        .res_bits (fmt_n),
        .tot_bits (fmt_np),
        .mblocks  (fmt_e)
    );

    // ==========================================
    // Derived field values, each sent minus one
    assign l_m1  = {1'b0, fmt_l} - 5'h01;
    assign f_m1  = {4'h0, fmt_f} - 8'h01;
    assign m_m1  = {4'h0, fmt_m} - 8'h01;
    assign n_m1  = {1'b0, fmt_n} - 5'h01;
    assign np_m1 = {1'b0, fmt_np} - 5'h01;
    assign s_m1  = {1'b0, fmt_s} - 5'h01;

    // Frames per multiframe: programmed, or fixed by E and F
    assign k_66 = (`ILPC_MB_SCALE * {8'h00, fmt_e}) / {6'h00, fmt_f};
    assign k_m1 = fmt_enc66 ? (k_66[7:0] - 8'h01) : klen_reg;

    // Lane identifier of the lane being sent
    assign lid       = LANE_ID_BASE + {2'h0, lane_reg};
    assign last_lane = l_m1[2:0];

    // ==========================================
    // Checksum over every field except the lane identifier
    always @* begin
        sum_base = {4'h0, devid_reg};
        sum_base = sum_base + {8'h00, `ILPC_ADJCNT};
        sum_base = sum_base + {8'h00, `ILPC_BID};
        sum_base = sum_base + {11'h000, `ILPC_ADJDIR};
        sum_base = sum_base + {11'h000, `ILPC_PHADJ};
        sum_base = sum_base + {11'h000, scram_reg};
        sum_base = sum_base + {7'h00, l_m1};
        sum_base = sum_base + {4'h0, f_m1};
        sum_base = sum_base + {4'h0, k_m1};
        sum_base = sum_base + {4'h0, m_m1};
        sum_base = sum_base + {10'h000, `ILPC_CS};
        sum_base = sum_base + {7'h00, n_m1};
        sum_base = sum_base + {9'h000, `ILPC_SUBCLASSV};
        sum_base = sum_base + {7'h00, np_m1};
        sum_base = sum_base + {9'h000, `ILPC_JESDV};
        sum_base = sum_base + {7'h00, s_m1};
        sum_base = sum_base + {11'h000, `ILPC_HD};
        sum_base = sum_base + {7'h00, `ILPC_CF};
        sum_base = sum_base + {4'h0, `ILPC_RES1};
        sum_base = sum_base + {4'h0, `ILPC_RES2};
    end

    // Modulo 256 by truncation, lane identifier added per lane
    assign chk_base = sum_base[7:0];
    assign chk_lane = chk_base + {3'h0, lid};

    // ==========================================
    // Register writes
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            format_reg <= `ILPC_RST_FORMAT;
            klen_reg   <= `ILPC_RST_KLEN;
            devid_reg  <= `ILPC_RST_DEVID;
            scram_reg  <= `ILPC_RST_SCRAM;
        end else if (reg_wr) begin
            case (reg_addr)
                `ILPC_REG_FORMAT: format_reg <= reg_wdata[3:0];
                `ILPC_REG_KLEN:   klen_reg   <= reg_wdata;
                `ILPC_REG_DEVID:  devid_reg  <= reg_wdata;
                `ILPC_REG_SCRAM:  scram_reg  <= reg_wdata[0];
                default: ;
            endcase
        end
    end

    // Register reads, data in the following cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ILPC_REG_FORMAT: reg_rdata <= {4'h0, format_reg};
                `ILPC_REG_KLEN:   reg_rdata <= klen_reg;
                `ILPC_REG_DEVID:  reg_rdata <= devid_reg;
                `ILPC_REG_SCRAM:  reg_rdata <= {7'h00, scram_reg};
                `ILPC_REG_STATUS: reg_rdata <= {5'h00, fmt_valid, fmt_enc66, state_reg};
                `ILPC_REG_LANES:  reg_rdata <= {4'h0, fmt_l};
                `ILPC_REG_KEFF:   reg_rdata <= k_m1;
                `ILPC_REG_CHKSUM: reg_rdata <= chk_base + {3'h0, LANE_ID_BASE};
                default:          reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================
    // Sequencer
    // Start only with a listed format and 8B/10B coding
    assign start_ok = ilas_start && fmt_valid && !fmt_enc66;
    assign load     = (state_reg == ST_SEND) && (!out_valid_reg || cfg_ready);

    // Next state
    always @* begin
        case (state_reg)
            ST_IDLE: state_next = start_ok ? ST_SEND : ST_IDLE;
            ST_SEND: state_next = (load && idx_reg == LAST_OCTET && lane_reg == last_lane)
                                  ? ST_IDLE : ST_SEND;
            default: state_next = ST_IDLE;
        endcase
    end

    // Lane and octet counters
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            lane_reg  <= 3'h0;
            idx_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE) begin
                lane_reg <= 3'h0;
                idx_reg  <= 4'h0;
            end else if (load) begin
                if (idx_reg == LAST_OCTET) begin
                    idx_reg  <= 4'h0;
                    lane_reg <= lane_reg + 3'h1;
                end else begin
                    idx_reg <= idx_reg + 4'h1;
                end
            end
        end
    end

    // Output handshake registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid_reg <= 1'b0;
            cfg_lane      <= 3'h0;
            cfg_index     <= 4'h0;
            cfg_last      <= 1'b0;
        end else if (load) begin
            out_valid_reg <= 1'b1;
            cfg_lane      <= lane_reg;
            cfg_index     <= idx_reg;
            cfg_last      <= (idx_reg == LAST_OCTET) && (lane_reg == last_lane);
        end else if (cfg_ready) begin
            out_valid_reg <= 1'b0;
            cfg_last      <= 1'b0;
        end
    end

    // Octet register
    ilpc_octet_sel u_oct (
        .clk   (clk),
        .rst_b (rst_b),
        .load  (load),
        .idx   (idx_reg),
        .did   (devid_reg),
        .lid   (lid),
        .scr   (scram_reg),
        .l_m1  (l_m1),
        .f_m1  (f_m1),
        .k_m1  (k_m1),
        .m_m1  (m_m1),
        .n_m1  (n_m1),
        .np_m1 (np_m1),
        .s_m1  (s_m1),
        .chk   (chk_lane),
        .octet (cfg_octet)
    );

    assign cfg_valid  = out_valid_reg;
    assign ilas_busy  = state_reg;
    assign enc_64b66b = fmt_enc66;

    // ==========================================
    // Multiframe counter: boundary every k_m1 + 1 frames
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_cnt_reg <= 8'h00;
            mf_boundary   <= 1'b0;
        end else if (frame_tick) begin
            if (frame_cnt_reg >= k_m1) begin
                frame_cnt_reg <= 8'h00;
                mf_boundary   <= 1'b1;
            end else begin
                frame_cnt_reg <= frame_cnt_reg + 8'h01;
                mf_boundary   <= 1'b0;
            end
        end else begin
            mf_boundary <= 1'b0;
        end
    end

endmodule

// [core/ilpc_consts.vh]
`ifndef ILPC_CONSTS_VH
`define ILPC_CONSTS_VH

// ==========================================
// Register map (index on an 8-bit address)
`define ILPC_REG_FORMAT   8'h00
`define ILPC_REG_KLEN     8'h01
`define ILPC_REG_DEVID    8'h02
`define ILPC_REG_SCRAM    8'h03
`define ILPC_REG_STATUS   8'h04
`define ILPC_REG_LANES    8'h05
`define ILPC_REG_KEFF     8'h06
`define ILPC_REG_CHKSUM   8'h07

// ==========================================
// Reset values
`define ILPC_RST_FORMAT   4'h0
`define ILPC_RST_KLEN     8'h1f
`define ILPC_RST_DEVID    8'h00
`define ILPC_RST_SCRAM    1'b0

// ==========================================
// Fixed field values of the parameter set
`define ILPC_ADJCNT       4'h0
`define ILPC_BID          4'h0
`define ILPC_ADJDIR       1'b0
`define ILPC_PHADJ        1'b0
`define ILPC_CF           5'h00
`define ILPC_CS           2'h0
`define ILPC_HD           1'b0
`define ILPC_SUBCLASSV    3'h1
`define ILPC_JESDV        3'h1
`define ILPC_RES1         8'h00
`define ILPC_RES2         8'h00

// ==========================================
// Octet positions in the parameter set
`define ILPC_OCT_DID      4'h0
`define ILPC_OCT_ADJ      4'h1
`define ILPC_OCT_LID      4'h2
`define ILPC_OCT_L        4'h3
`define ILPC_OCT_F        4'h4
`define ILPC_OCT_K        4'h5
`define ILPC_OCT_M        4'h6
`define ILPC_OCT_N        4'h7
`define ILPC_OCT_NP       4'h8
`define ILPC_OCT_S        4'h9
`define ILPC_OCT_HD       4'ha
`define ILPC_OCT_RES1     4'hb
`define ILPC_OCT_RES2     4'hc
`define ILPC_OCT_CHK      4'hd

// ==========================================
// Multiblock scale for 64B/66B: 8 x 32
`define ILPC_MB_SCALE     10'h100

`endif

// [core/ilpc_mode_rom.v]
`include "ilpc_consts.vh"

// ==========================================
// Format table: transport parameters per format code, registered output
module ilpc_mode_rom (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // Lookup
    input  wire [3:0] mode,
    output reg        valid,
    output reg        enc66,
    output reg  [3:0] lanes,
    output reg  [3:0] convs,
    output reg  [3:0] octets,
    output reg  [3:0] samples,
    output reg  [3:0] res_bits,
    output reg  [3:0] tot_bits,
    output reg  [1:0] mblocks
);

    reg [27:0] row;

    // Columns: valid, enc66, L, M, F, S, N, N', E
    always @* begin
        case (mode)
            4'h0:    row = {1'b1, 1'b0, 4'h8, 4'h8, 4'h8, 4'h5, 4'h9, 4'hc, 2'h0};
            4'h1:    row = {1'b1, 1'b0, 4'h6, 4'h4, 4'h2, 4'h2, 4'h9, 4'hc, 2'h0};
            4'h2:    row = {1'b1, 1'b0, 4'h4, 4'h4, 4'h1, 4'h1, 4'h8, 4'h8, 2'h0};
            4'h3:    row = {1'b1, 1'b0, 4'h4, 4'h4, 4'h5, 4'h4, 4'h9, 4'ha, 2'h0};
            4'h4:    row = {1'b1, 1'b1, 4'h3, 4'h4, 4'h2, 4'h1, 4'h9, 4'hc, 2'h1};
            4'h5:    row = {1'b1, 1'b1, 4'h2, 4'h4, 4'h2, 4'h1, 4'h8, 4'h8, 2'h1};
            4'h6:    row = {1'b1, 1'b1, 4'h6, 4'h4, 4'h2, 4'h2, 4'h9, 4'hc, 2'h1};
            4'h7:    row = {1'b1, 1'b1, 4'h4, 4'h4, 4'h1, 4'h1, 4'h8, 4'h8, 2'h1};
            4'h8:    row = {1'b1, 1'b1, 4'h4, 4'h4, 4'h3, 4'h2, 4'h9, 4'hc, 2'h3};
            4'h9:    row = {1'b1, 1'b0, 4'h8, 4'h4, 4'h1, 4'h2, 4'h8, 4'h8, 2'h0};
            4'ha:    row = {1'b1, 1'b0, 4'h8, 4'h8, 4'h5, 4'h4, 4'h9, 4'ha, 2'h0};
            4'he:    row = {1'b1, 1'b1, 4'h8, 4'h8, 4'h3, 4'h2, 4'h9, 4'hc, 2'h3};
            default: row = {1'b0, 1'b0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 2'h1};
        endcase
    end

    // Output register
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {valid, enc66, lanes, convs, octets, samples, res_bits, tot_bits, mblocks}
                <= {1'b0, 1'b0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 2'h1};
        end else begin
            {valid, enc66, lanes, convs, octets, samples, res_bits, tot_bits, mblocks} <= row;
        end
    end

endmodule

// [core/ilpc_octet_sel.v]
`include "ilpc_consts.vh"

// ==========================================
// Parameter set octet selector, registered on load
module ilpc_octet_sel (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // Select
    input  wire       load,
    input  wire [3:0] idx,
    // Encoded fields
    input  wire [7:0] did,
    input  wire [4:0] lid,
    input  wire       scr,
    input  wire [4:0] l_m1,
    input  wire [7:0] f_m1,
    input  wire [7:0] k_m1,
    input  wire [7:0] m_m1,
    input  wire [4:0] n_m1,
    input  wire [4:0] np_m1,
    input  wire [4:0] s_m1,
    input  wire [7:0] chk,
    // Octet out
    output reg  [7:0] octet
);

    reg [7:0] sel;

    // Octet layout of the parameter set
    always @* begin
        case (idx)
            `ILPC_OCT_DID:  sel = did;
            `ILPC_OCT_ADJ:  sel = {`ILPC_ADJCNT, `ILPC_BID};
            `ILPC_OCT_LID:  sel = {1'b0, `ILPC_ADJDIR, `ILPC_PHADJ, lid};
            `ILPC_OCT_L:    sel = {scr, 2'h0, l_m1};
            `ILPC_OCT_F:    sel = f_m1;
            `ILPC_OCT_K:    sel = k_m1;
            `ILPC_OCT_M:    sel = m_m1;
            `ILPC_OCT_N:    sel = {`ILPC_CS, 1'b0, n_m1};
            `ILPC_OCT_NP:   sel = {`ILPC_SUBCLASSV, np_m1};
            `ILPC_OCT_S:    sel = {`ILPC_JESDV, s_m1};
            `ILPC_OCT_HD:   sel = {`ILPC_HD, 2'h0, `ILPC_CF};
            `ILPC_OCT_RES1: sel = `ILPC_RES1;
            `ILPC_OCT_RES2: sel = `ILPC_RES2;
            `ILPC_OCT_CHK:  sel = chk;
            default:        sel = 8'h00;
        endcase
    end

    // Output register
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            octet <= 8'h00;
        end else if (load) begin
            octet <= sel;
        end
    end

endmodule

// [bench/ilpc_props.sv]
// ==========================================
// Port checker for the parameter octet stream and multiframe pulse
module ilpc_props #(
    parameter LANE_ID_BASE = 5'h00
) (
    input logic       clk,
    input logic       rst_b,
    input logic       ilas_start,
    input logic       frame_tick,
    input logic       mf_boundary,
    input logic       ilas_busy,
    input logic       enc_64b66b,
    input logic       cfg_valid,
    input logic       cfg_ready,
    input logic [2:0] cfg_lane,
    input logic [3:0] cfg_index,
    input logic [7:0] cfg_octet,
    input logic       cfg_last
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ==========================================
    // Sequence start, order and end
    chk_busy_cause: assert property ($rose(ilas_busy) |-> $past(ilas_start) && !$past(enc_64b66b))
        else $error("busy rose without an accepted start");
    chk_first_octet: assert property ($rose(ilas_busy) |=> cfg_valid && cfg_lane == 3'h0
        && cfg_index == 4'h0) else $error("first octet late or misplaced");
    chk_hold_stall: assert property (cfg_valid && !cfg_ready |=> cfg_valid
        && $stable({cfg_lane, cfg_index, cfg_octet})) else $error("octet changed while stalled");
    chk_index_step: assert property (cfg_valid && cfg_ready && cfg_index != 4'hd |=> cfg_valid
        && cfg_index == $past(cfg_index) + 4'h1 && $stable(cfg_lane)) else $error("index skipped");
    chk_lane_step: assert property (cfg_valid && cfg_ready && cfg_index == 4'hd && !cfg_last |=>
        cfg_index == 4'h0 && cfg_lane == $past(cfg_lane) + 3'h1) else $error("lane order broken");
    chk_last_ends: assert property (cfg_valid && cfg_ready && cfg_last |=> !cfg_valid && !ilas_busy)
        else $error("stream ran past last octet");
    // ==========================================
    // Fixed fields, lane identifier and multiframe pulse cause
    chk_adj_zero: assert property (cfg_valid && cfg_index == 4'h1 |-> cfg_octet == 8'h00)
        else $error("adjust amount not zero");
    chk_lid_octet: assert property (cfg_valid && cfg_index == 4'h2 |->
        cfg_octet == {3'h0, LANE_ID_BASE + {2'h0, cfg_lane}}) else $error("lane id wrong");
    chk_cs_zero: assert property (cfg_valid && cfg_index == 4'h7 |-> cfg_octet[7:5] == 3'h0)
        else $error("control bits field not zero");
    chk_hd_cf: assert property (cfg_valid && cfg_index == 4'ha |-> cfg_octet == 8'h00)
        else $error("density or control words not zero");
    chk_mf_cause: assert property (mf_boundary |-> $past(frame_tick))
        else $error("multiframe pulse without frame tick");

    // Main scenarios reached
    cov_stall: cover property (cfg_valid && !cfg_ready);
    cov_last: cover property (cfg_valid && cfg_ready && cfg_last);
    cov_mf: cover property (mf_boundary);
    cov_start: cover property ($rose(ilas_busy));
endmodule

bind ilpc_top ilpc_props #(.LANE_ID_BASE(LANE_ID_BASE)) i_ilpc_props (
    .clk(clk), .rst_b(rst_b), .ilas_start(ilas_start), .frame_tick(frame_tick),
    .mf_boundary(mf_boundary), .ilas_busy(ilas_busy), .enc_64b66b(enc_64b66b),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_lane(cfg_lane),
    .cfg_index(cfg_index), .cfg_octet(cfg_octet), .cfg_last(cfg_last)
);

// [bench/ilpc_rx_model.sv]
// ==========================================
// Link receiver stand-in: takes octets, stalls at random when asked
module ilpc_rx_model (
    input  logic clk,
    input  logic rst_b,
    input  logic stall_en,
    output logic cfg_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    // Ready is a level; random while stalling, else always high
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ready <= 1'b0;
        end else begin
            cfg_ready <= stall_en ? 1'($urandom_range(1, 0)) : 1'b1;
        end
    end
endmodule

// [bench/tb_ilas_parameter_config.sv]
`include "ilpc_consts.vh"

module tb_ilas_parameter_config;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] LBASE = 5'h03;
    logic        clk, rst_b, reg_wr, reg_rd, ilas_start, frame_tick, stall_en, cfg_ready;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, cfg_octet, did, klen;
    logic        mf_boundary, ilas_busy, enc_64b66b, cfg_valid, cfg_last, scr, rd_seen;
    logic [2:0]  cfg_lane;
    logic [3:0]  cfg_index, fmt;
    logic [7:0]  rd_q[$];
    logic [15:0] oc_q[$];
    int          n_errors, samples_checked, tick_cnt, mf_skip;

    ilpc_top #(.LANE_ID_BASE(LBASE)) i_ilpc_top (.clk(clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ilas_start(ilas_start), .frame_tick(frame_tick),
        .mf_boundary(mf_boundary), .ilas_busy(ilas_busy), .enc_64b66b(enc_64b66b),
        .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_lane(cfg_lane),
        .cfg_index(cfg_index), .cfg_octet(cfg_octet), .cfg_last(cfg_last));
    ilpc_rx_model i_ilpc_rx_model (.clk(clk), .rst_b(rst_b), .stall_en(stall_en),
        .cfg_ready(cfg_ready));

    // ==========================================
    // Format table {L, M, F, S, N, N'}; zero marks an unlisted code
    function automatic logic [23:0] tbl(input logic [3:0] m);
        case (m)
            4'h0: return 24'h88859c;
            4'h1, 4'h6: return 24'h64229c;
            4'h2, 4'h7: return 24'h441188;
            4'h3: return 24'h44549a;
            4'h4: return 24'h34219c;
            4'h5: return 24'h242188;
            4'h8: return 24'h44329c;
            4'h9: return 24'h841288;
            4'ha: return 24'h88549a;
            4'he: return 24'h88329c;
            default: return 24'h0;
        endcase
    endfunction
    function automatic logic e66(input logic [3:0] m);
        return (m >= 4'h4 && m <= 4'h8) || m == 4'he;
    endfunction
    // Frames per multiframe in force
    function automatic int kval(input logic [3:0] m);
        case (m)
            4'h4, 4'h5, 4'h6: return 128;
            4'h7, 4'h8, 4'he: return 256;
            default: return klen + 1;
        endcase
    endfunction
    // Expected octet of the parameter set
    function automatic logic [7:0] eo(input logic [3:0] m, input logic [2:0] ln, input logic [3:0] ix);
        logic [23:0] t;
        logic [7:0]  lid;
        t = tbl(m);
        lid = {3'h0, LBASE + {2'h0, ln}};
        case (ix)
            4'h0: return did;
            4'h2: return lid;
            4'h3: return {scr, 3'h0, t[23:20] - 4'h1};
            4'h4: return {4'h0, t[15:12] - 4'h1};
            4'h5: return klen;
            4'h6: return {4'h0, t[19:16] - 4'h1};
            4'h7: return {4'h0, t[7:4] - 4'h1};
            4'h8: return {4'h2, t[3:0] - 4'h1};
            4'h9: return {4'h2, t[11:8] - 4'h1};
            4'hd: return did + lid + {7'h0, scr} + klen + t[23:20] + t[19:16] + t[15:12]
                + t[11:8] + t[7:4] + t[3:0] - 8'h04;
            default: return 8'h00;
        endcase
    endfunction

    // ==========================================
    // Compare tasks and closing report
    task automatic cmp_reg(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cmp_oct(input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR octet expected %h seen %h", e, s);
        end
    endtask
    task automatic cmp_cnt(input int e, input int s);
        samples_checked++;
        if (s != e) begin
            n_errors++;
            $display("ERROR frames per multiframe expected %0d seen %0d", e, s);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================
    // Register bus tasks; writes also update the shadow copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == `ILPC_REG_FORMAT) fmt = d[3:0];
        if (a == `ILPC_REG_KLEN) klen = d;
        if (a == `ILPC_REG_DEVID) did = d;
        if (a == `ILPC_REG_SCRAM) scr = d[0];
        if (a <= `ILPC_REG_KLEN) mf_skip = 2;
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic pulse;
        @(posedge clk);
        ilas_start <= 1'b1;
        @(posedge clk);
        ilas_start <= 1'b0;
    endtask
    // Start a sequence, note all octets, wait bounded for the end
    task automatic ilas(input logic twice);
        int n;
        logic [23:0] t;
        t = tbl(fmt);
        for (int ln = 0; ln < t[23:20]; ln++)
            for (int ix = 0; ix < 14; ix++)
                oc_q.push_back({ln[2:0], ix[3:0], eo(fmt, ln[2:0], ix[3:0]),
                    1'(ln == t[23:20] - 1 && ix == 13)});
        pulse();
        if (twice) begin
            repeat (4) @(posedge clk);
            pulse();
        end
        n = 0;
        while ((oc_q.size() != 0 || ilas_busy !== 1'b0) && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            n_errors++;
            end_of_test();
        end
    endtask

    // ==========================================
    // Monitor: read data, octets and multiframe spacing
    always @(posedge clk) begin
        if (rd_seen) cmp_reg("reg_rdata", rd_q.pop_front(), reg_rdata);
        rd_seen <= reg_rd;
        if (cfg_valid === 1'b1 && cfg_ready === 1'b1)
            cmp_oct(oc_q.pop_front(), {cfg_lane, cfg_index, cfg_octet, cfg_last});
        if (mf_boundary === 1'b1) begin
            if (mf_skip == 0 && tbl(fmt) != 24'h0) cmp_cnt(kval(fmt), tick_cnt);
            else if (mf_skip > 0) mf_skip--;
            tick_cnt = 0;
        end
        if (frame_tick === 1'b1) tick_cnt++;
    end
    // Random frame ticks
    always @(posedge clk) frame_tick <= 1'($urandom_range(1, 0));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================
    // Main sequence
    initial begin
        int k;
        {rst_b, reg_wr, reg_rd, ilas_start, frame_tick, stall_en, rd_seen} = '0;
        {reg_addr, reg_wdata} = '0;
        {fmt, did, scr, klen} = {4'h0, 8'h00, 1'b0, 8'h1f};
        {n_errors, samples_checked, tick_cnt, mf_skip} = {32'd0, 32'd0, 32'd0, 32'd2};
        void'($urandom(66));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, read-only and unmapped places
        rd(`ILPC_REG_FORMAT, 8'h00);
        rd(`ILPC_REG_KLEN, 8'h1f);
        rd(`ILPC_REG_DEVID, 8'h00);
        wr(`ILPC_REG_STATUS, 8'hff);
        rd(`ILPC_REG_STATUS, 8'h04);
        rd(8'h3c, 8'h00);
        // Every code: derived registers, or start refused
        for (int m = 0; m < 16; m++) begin
            wr(`ILPC_REG_FORMAT, m[7:0]);
            if (tbl(m[3:0]) != 24'h0) begin
                rd(`ILPC_REG_STATUS, {5'h0, 1'b1, e66(m[3:0]), 1'b0});
                rd(`ILPC_REG_LANES, {4'h0, tbl(m[3:0]) >> 20});
                rd(`ILPC_REG_KEFF, 8'(kval(m[3:0]) - 1));
            end
            if (tbl(m[3:0]) == 24'h0 || e66(m[3:0])) begin
                pulse();
                repeat (3) @(posedge clk);
                cmp_reg("ilas_busy", 8'h00, {7'h0, ilas_busy});
            end
        end
        // Sequences in every 8B/10B format with random settings
        for (int i = 0; i < 6; i++) begin
            k = (i == 0) ? 4 : (i == 1) ? 16 : 32;
            wr(`ILPC_REG_FORMAT, (i < 4) ? i[7:0] : 8'(i + 5));
            wr(`ILPC_REG_DEVID, 8'($urandom));
            wr(`ILPC_REG_SCRAM, 8'($urandom_range(1, 0)));
            wr(`ILPC_REG_KLEN, 8'(k * $urandom_range(256 / k, 1) - 1));
            stall_en <= fmt[0];
            ilas(i == 3);
            rd(`ILPC_REG_CHKSUM, eo(fmt, 3'h0, 4'hd));
            rd(`ILPC_REG_KEFF, klen);
            repeat (150) @(posedge clk);
        end
        // Multiframe length in 64B/66B formats
        wr(`ILPC_REG_FORMAT, 8'h04);
        repeat (1200) @(posedge clk);
        wr(`ILPC_REG_FORMAT, 8'h07);
        repeat (2400) @(posedge clk);
        end_of_test();
    end
endmodule
